// ===== src/cvt_pkg.sv
// Constants, register map and carrier types for the calibration vector and trim bank
package cvt_pkg;
  localparam int            ADDR_W       = 12;
  localparam int            VEC_LEN      = 673;
  localparam int            IDX_W        = 10;
  localparam logic [9:0]    IDX_CAL_EN   = 10'h070;
  localparam logic [9:0]    IDX_CAL_DATA = 10'h071;
  localparam logic [9:0]    IDX_GAIN_A   = 10'h07a;
  localparam logic [9:0]    IDX_GAIN_B   = 10'h07b;
  localparam logic [9:0]    IDX_REF      = 10'h07c;
  localparam logic [9:0]    IDX_TERM_A   = 10'h07e;
  localparam logic [9:0]    IDX_TERM_B   = 10'h07f;
  localparam logic [9:0]    IDX_SKEW_AF  = 10'h080;
  localparam logic [9:0]    IDX_SKEW_BF  = 10'h081;
  localparam logic [9:0]    IDX_SKEW_AB  = 10'h082;
  localparam logic [9:0]    IDX_CFG      = 10'h0f0;
  localparam logic [9:0]    IDX_STAT     = 10'h0f1;
  localparam int            EN_BIT       = 0;
  localparam int            HOLD_BIT     = 0;
  localparam int            STAT_HALT    = 0;
  localparam int            STAT_VALID   = 1;
  localparam int            STAT_IDX_LSB = 16;
  localparam logic [7:0]    REF_MASK     = 8'h0f;
  localparam logic [7:0]    CAL_EN_RST   = 8'h00;
  localparam logic [7:0]    CFG_RST      = 8'h00;
  localparam logic [1:0]    RESP_OKAY    = 2'b00;
  localparam logic [1:0]    RESP_SLVERR  = 2'b10;

  typedef struct packed {
    logic [7:0] gain_a;
    logic [7:0] gain_b;
    logic [7:0] ref_v;
    logic [7:0] term_a;
    logic [7:0] term_b;
    logic [7:0] skew_a_fg;
    logic [7:0] skew_b_fg;
    logic [7:0] skew_a_bg;
  } cvt_trim_type;

  typedef struct packed {
    logic core_b;
    logic dual_mode;
    logic bg_phase;
  } cvt_skew_sel_type;

  // Factory trim image; values arbitrary
  localparam cvt_trim_type FACTORY_TRIM = 64'h8080_0880_8080_8080;
endpackage : cvt_pkg

// ===== src/cvt_regs.sv
// AXI4-Lite register bank for calibration vector access and factory trims
module cvt_regs #(
  parameter int                   VEC_LEN = cvt_pkg::VEC_LEN,
  parameter cvt_pkg::cvt_trim_type FACTORY = cvt_pkg::FACTORY_TRIM
) (
  input  wire logic                      clock_i,
  input  wire logic                      rst_i,
  input  wire logic [cvt_pkg::ADDR_W-1:0] awaddr_i,
  input  wire logic                      awvalid_i,
  output logic                           awready_o,
  input  wire logic [31:0]               wdata_i,
  input  wire logic [3:0]                wstrb_i,
  input  wire logic                      wvalid_i,
  output logic                           wready_o,
  output logic [1:0]                     bresp_o,
  output logic                           bvalid_o,
  input  wire logic                      bready_i,
  input  wire logic [cvt_pkg::ADDR_W-1:0] araddr_i,
  input  wire logic                      arvalid_i,
  output logic                           arready_o,
  output logic [31:0]                    rdata_o,
  output logic [1:0]                     rresp_o,
  output logic                           rvalid_o,
  input  wire logic                      rready_i,
  input  wire logic                      calibration_halted_flag_i,
  input  wire cvt_pkg::cvt_skew_sel_type skew_sel_i,
  output cvt_pkg::cvt_trim_type          trim_o,
  output logic [7:0]                     applied_skew_o,
  output logic                           applied_skew_ok_o,
  output logic                           address_hold_o,
  output logic                           vector_valid_o
);
  localparam int IW = cvt_pkg::IDX_W;

  if (VEC_LEN < 2 || VEC_LEN > (1 << IW)) begin : g_len_chk
    $error("VEC_LEN out of range");
  end

  cvt_pkg::cvt_trim_type trim_ff, nxt_trim;
  logic [7:0]    cal_en_ff, nxt_cal_en;
  logic [7:0]    cfg_ff, nxt_cfg;
  logic [IW-1:0] idx_ff, nxt_idx;
  logic          valid_ff, nxt_valid;
  logic          aw_ok_ff, nxt_aw_ok;
  logic          w_ok_ff, nxt_w_ok;
  logic          ar_ok_ff, nxt_ar_ok;
  logic [cvt_pkg::ADDR_W-1:0] awaddr_ff, nxt_awaddr;
  logic [cvt_pkg::ADDR_W-1:0] araddr_ff, nxt_araddr;
  logic [31:0]   wdata_ff, nxt_wdata;
  logic [3:0]    wstrb_ff, nxt_wstrb;
  logic          awready_ff, nxt_awready;
  logic          wready_ff, nxt_wready;
  logic          arready_ff, nxt_arready;
  logic          bvalid_ff, nxt_bvalid;
  logic [1:0]    bresp_ff, nxt_bresp;
  logic          rvalid_ff, nxt_rvalid;
  logic [1:0]    rresp_ff, nxt_rresp;
  logic [31:0]   rdata_ff, nxt_rdata;
  logic [7:0]    skew_ff, nxt_skew;
  logic          skew_ok_ff, nxt_skew_ok;
  logic [7:0]    mem_ff [VEC_LEN];
  logic          mem_we;
  logic [7:0]    mem_wd;
  logic          do_wr;
  logic          do_rd;
  logic          port_acc;
  logic [9:0]    wr_idx;
  logic [9:0]    rd_idx;
  logic          wr_hi_ok;
  logic          rd_hi_ok;
  logic [7:0]    wb;

  assign do_wr    = aw_ok_ff && w_ok_ff && !bvalid_ff;
  assign do_rd    = ar_ok_ff && !rvalid_ff && !do_wr;
  assign wr_idx   = awaddr_ff[11:2];
  assign rd_idx   = araddr_ff[11:2];
  assign wr_hi_ok = (awaddr_ff[1:0] == 2'b00);
  assign rd_hi_ok = (araddr_ff[1:0] == 2'b00);
  assign wb       = wdata_ff[7:0];

  // Bus channel handshakes
  always_comb begin
    nxt_aw_ok   = aw_ok_ff;
    nxt_w_ok    = w_ok_ff;
    nxt_ar_ok   = ar_ok_ff;
    nxt_awaddr  = awaddr_ff;
    nxt_araddr  = araddr_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_rvalid  = rvalid_ff;
    if (awvalid_i && awready_ff) begin
      nxt_aw_ok  = 1'b1;
      nxt_awaddr = awaddr_i;
    end
    if (wvalid_i && wready_ff) begin
      nxt_w_ok  = 1'b1;
      nxt_wdata = wdata_i;
      nxt_wstrb = wstrb_i;
    end
    if (arvalid_i && arready_ff) begin
      nxt_ar_ok  = 1'b1;
      nxt_araddr = araddr_i;
    end
    if (do_wr) begin
      nxt_aw_ok  = 1'b0;
      nxt_w_ok   = 1'b0;
      nxt_bvalid = 1'b1;
    end else if (bvalid_ff && bready_i) begin
      nxt_bvalid = 1'b0;
    end
    if (do_rd) begin
      nxt_ar_ok  = 1'b0;
      nxt_rvalid = 1'b1;
    end else if (rvalid_ff && rready_i) begin
      nxt_rvalid = 1'b0;
    end
    nxt_awready = !nxt_aw_ok && !nxt_bvalid;
    nxt_wready  = !nxt_w_ok && !nxt_bvalid;
    nxt_arready = !nxt_ar_ok && !nxt_rvalid;
  end

  // Register file, vector index and read data
  always_comb begin
    nxt_trim    = trim_ff;
    nxt_cal_en  = cal_en_ff;
    nxt_cfg     = cfg_ff;
    nxt_idx     = idx_ff;
    nxt_valid   = valid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rresp   = rresp_ff;
    nxt_rdata   = rdata_ff;
    mem_we      = 1'b0;
    mem_wd      = wb;
    port_acc    = 1'b0;
    if (do_wr) begin
      nxt_bresp = cvt_pkg::RESP_OKAY;
      if (!wr_hi_ok) begin
        nxt_bresp = cvt_pkg::RESP_SLVERR;
      end else if (wstrb_ff[0]) begin
        case (wr_idx)
          cvt_pkg::IDX_CAL_EN: begin
            nxt_cal_en = wb;
            if (wb[cvt_pkg::EN_BIT] && !cal_en_ff[cvt_pkg::EN_BIT]) begin
              nxt_idx   = '0;
              nxt_valid = 1'b0;
            end else if (!wb[cvt_pkg::EN_BIT] && cal_en_ff[cvt_pkg::EN_BIT]
                         && idx_ff != '0) begin
              nxt_valid = 1'b0;
            end
          end
          cvt_pkg::IDX_CAL_DATA: begin
            if (cal_en_ff[cvt_pkg::EN_BIT]) begin
              mem_we   = 1'b1;
              port_acc = 1'b1;
            end
          end
          cvt_pkg::IDX_GAIN_A:  nxt_trim.gain_a    = wb;
          cvt_pkg::IDX_GAIN_B:  nxt_trim.gain_b    = wb;
          cvt_pkg::IDX_REF:     nxt_trim.ref_v     = wb;
          cvt_pkg::IDX_TERM_A:  nxt_trim.term_a    = wb;
          cvt_pkg::IDX_TERM_B:  nxt_trim.term_b    = wb;
          cvt_pkg::IDX_SKEW_AF: nxt_trim.skew_a_fg = wb;
          cvt_pkg::IDX_SKEW_BF: nxt_trim.skew_b_fg = wb;
          cvt_pkg::IDX_SKEW_AB: nxt_trim.skew_a_bg = wb;
          cvt_pkg::IDX_CFG:     nxt_cfg            = wb;
          cvt_pkg::IDX_STAT:    nxt_bresp          = cvt_pkg::RESP_OKAY;
          default:              nxt_bresp          = cvt_pkg::RESP_SLVERR;
        endcase
      end
    end
    if (do_rd) begin
      nxt_rdata = '0;
      nxt_rresp = cvt_pkg::RESP_OKAY;
      if (!rd_hi_ok) begin
        nxt_rresp = cvt_pkg::RESP_SLVERR;
      end else begin
        case (rd_idx)
          cvt_pkg::IDX_CAL_EN:  nxt_rdata[7:0] = cal_en_ff;
          cvt_pkg::IDX_CAL_DATA: begin
            if (cal_en_ff[cvt_pkg::EN_BIT]) begin
              nxt_rdata[7:0] = mem_ff[idx_ff];
              port_acc       = 1'b1;
            end
          end
          cvt_pkg::IDX_GAIN_A:  nxt_rdata[7:0] = trim_ff.gain_a;
          cvt_pkg::IDX_GAIN_B:  nxt_rdata[7:0] = trim_ff.gain_b;
          cvt_pkg::IDX_REF:     nxt_rdata[7:0] = trim_ff.ref_v;
          cvt_pkg::IDX_TERM_A:  nxt_rdata[7:0] = trim_ff.term_a;
          cvt_pkg::IDX_TERM_B:  nxt_rdata[7:0] = trim_ff.term_b;
          cvt_pkg::IDX_SKEW_AF: nxt_rdata[7:0] = trim_ff.skew_a_fg;
          cvt_pkg::IDX_SKEW_BF: nxt_rdata[7:0] = trim_ff.skew_b_fg;
          cvt_pkg::IDX_SKEW_AB: nxt_rdata[7:0] = trim_ff.skew_a_bg;
          cvt_pkg::IDX_CFG:     nxt_rdata[7:0] = cfg_ff;
          cvt_pkg::IDX_STAT: begin
            nxt_rdata[cvt_pkg::STAT_HALT]  = calibration_halted_flag_i;
            nxt_rdata[cvt_pkg::STAT_VALID] = valid_ff;
            nxt_rdata[cvt_pkg::STAT_IDX_LSB +: IW] = idx_ff;
          end
          default: nxt_rresp = cvt_pkg::RESP_SLVERR;
        endcase
      end
    end
    // Write and read never hit the port together: one access per cycle
    if (port_acc) begin
      if (idx_ff == IW'(VEC_LEN - 1)) begin
        nxt_idx   = '0;
        nxt_valid = calibration_halted_flag_i;
      end else begin
        nxt_idx = idx_ff + 1'b1;
      end
      if (!calibration_halted_flag_i) begin
        nxt_valid = 1'b0;
      end
    end
  end

  // Skew register selection
  always_comb begin
    nxt_skew    = 8'h00;
    nxt_skew_ok = 1'b0;
    if (!skew_sel_i.dual_mode) begin
      case ({skew_sel_i.core_b, skew_sel_i.bg_phase})
        2'b00:   nxt_skew = trim_ff.skew_a_fg;
        2'b10:   nxt_skew = trim_ff.skew_b_fg;
        2'b01:   nxt_skew = trim_ff.skew_a_bg;
        default: nxt_skew = 8'h00;
      endcase
      nxt_skew_ok = ({skew_sel_i.core_b, skew_sel_i.bg_phase} != 2'b11);
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      trim_ff    <= FACTORY & ~cvt_pkg::cvt_trim_type'({16'h0000, ~cvt_pkg::REF_MASK, 40'h0});
      cal_en_ff  <= cvt_pkg::CAL_EN_RST;
      cfg_ff     <= cvt_pkg::CFG_RST;
      idx_ff     <= '0;
      valid_ff   <= 1'b0;
      aw_ok_ff   <= 1'b0;
      w_ok_ff    <= 1'b0;
      ar_ok_ff   <= 1'b0;
      awaddr_ff  <= '0;
      araddr_ff  <= '0;
      wdata_ff   <= '0;
      wstrb_ff   <= '0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      arready_ff <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= cvt_pkg::RESP_OKAY;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= cvt_pkg::RESP_OKAY;
      rdata_ff   <= '0;
      skew_ff    <= 8'h00;
      skew_ok_ff <= 1'b0;
    end else begin
      trim_ff    <= nxt_trim;
      cal_en_ff  <= nxt_cal_en;
      cfg_ff     <= nxt_cfg;
      idx_ff     <= nxt_idx;
      valid_ff   <= nxt_valid;
      aw_ok_ff   <= nxt_aw_ok;
      w_ok_ff    <= nxt_w_ok;
      ar_ok_ff   <= nxt_ar_ok;
      awaddr_ff  <= nxt_awaddr;
      araddr_ff  <= nxt_araddr;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      arready_ff <= nxt_arready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      rvalid_ff  <= nxt_rvalid;
      rresp_ff   <= nxt_rresp;
      rdata_ff   <= nxt_rdata;
      skew_ff    <= nxt_skew;
      skew_ok_ff <= nxt_skew_ok;
    end
  end

  // Vector storage, contents undefined after reset
  always_ff @(posedge clock_i) begin
    if (mem_we) begin
      mem_ff[idx_ff] <= mem_wd;
    end
  end

  assign awready_o         = awready_ff;
  assign wready_o          = wready_ff;
  assign arready_o         = arready_ff;
  assign bvalid_o          = bvalid_ff;
  assign bresp_o           = bresp_ff;
  assign rvalid_o          = rvalid_ff;
  assign rresp_o           = rresp_ff;
  assign rdata_o           = rdata_ff;
  assign trim_o            = trim_ff;
  assign applied_skew_o    = skew_ff;
  assign applied_skew_ok_o = skew_ok_ff;
  assign address_hold_o    = cfg_ff[cvt_pkg::HOLD_BIT];
  assign vector_valid_o    = valid_ff;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  logic wr_ok_strb;
  logic en_on;
  assign wr_ok_strb = do_wr && wr_hi_ok && wstrb_ff[0];
  assign en_on      = cal_en_ff[cvt_pkg::EN_BIT];

  sequence s_port_read;
    do_rd && rd_hi_ok && rd_idx == cvt_pkg::IDX_CAL_DATA && en_on;
  endsequence
  sequence s_port_write;
    wr_ok_strb && wr_idx == cvt_pkg::IDX_CAL_DATA && en_on;
  endsequence

  property p_idx_adv;
    s_port_read ##0 (idx_ff != IW'(VEC_LEN - 1)) |=> idx_ff == $past(idx_ff) + 1'b1;
  endproperty
  a_idx_adv: assert property (p_idx_adv) else $error("index did not advance");

  property p_read_data;
    s_port_read |=> rvalid_o && rdata_o[7:0] == mem_ff[$past(idx_ff)];
  endproperty
  a_read_data: assert property (p_read_data) else $error("wrong vector byte");

  property p_write_load;
    s_port_write |=> mem_ff[$past(idx_ff)] == $past(wb);
  endproperty
  a_write_load: assert property (p_write_load) else $error("vector entry not loaded");

  property p_restart;
    wr_ok_strb && wr_idx == cvt_pkg::IDX_CAL_EN && wb[0] && !en_on |=> idx_ff == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("index not restarted");

  property p_early_end;
    wr_ok_strb && wr_idx == cvt_pkg::IDX_CAL_EN && !wb[0] && en_on && idx_ff != '0
      |=> !vector_valid_o;
  endproperty
  a_early_end: assert property (p_early_end) else $error("partial vector valid");

  property p_disabled;
    !en_on && !(wr_ok_strb && wr_idx == cvt_pkg::IDX_CAL_EN) |=> $stable(idx_ff);
  endproperty
  a_disabled: assert property (p_disabled) else $error("port moved while off");

  property p_gain_a;
    wr_ok_strb && wr_idx == cvt_pkg::IDX_GAIN_A |=> trim_o.gain_a == $past(wb);
  endproperty
  a_gain_a: assert property (p_gain_a) else $error("gain A not written");

  property p_skew_sel;
    !skew_sel_i.dual_mode && skew_sel_i.core_b && !skew_sel_i.bg_phase
      |=> applied_skew_ok_o && applied_skew_o == $past(trim_ff.skew_b_fg);
  endproperty
  a_skew_sel: assert property (p_skew_sel) else $error("wrong skew applied");

  property p_wr_answer;
    awvalid_i && awready_o && wvalid_i && wready_o |-> ##2 bvalid_o;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("late write answer");
endmodule : cvt_regs

// ===== testbench/test_calibration_vector_and_trim_regs.sv
// Self-checking bench for the calibration vector and trim register bank
module test_calibration_vector_and_trim_regs;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [9:0] TIDX [8] = '{cvt_pkg::IDX_GAIN_A, cvt_pkg::IDX_GAIN_B,
    cvt_pkg::IDX_REF, cvt_pkg::IDX_TERM_A, cvt_pkg::IDX_TERM_B, cvt_pkg::IDX_SKEW_AF,
    cvt_pkg::IDX_SKEW_BF, cvt_pkg::IDX_SKEW_AB};

  logic                       clock = 1'b0;
  logic                       rst;
  logic [11:0]                awaddr;
  logic                       awvalid;
  logic                       awready;
  logic [31:0]                wdata;
  logic                       wvalid;
  logic                       wready;
  logic [1:0]                 bresp;
  logic                       bvalid;
  logic [11:0]                araddr;
  logic                       arvalid;
  logic                       arready;
  logic [31:0]                rdata;
  logic [1:0]                 rresp;
  logic                       rvalid;
  logic                       halted;
  cvt_pkg::cvt_skew_sel_type  sel;
  cvt_pkg::cvt_trim_type      trim;
  logic [7:0]                 askew;
  logic                       askew_ok;
  logic                       hold;
  logic                       vvalid;
  logic [7:0]                 wv [8];
  int                         bad_count = 0;
  int                         n_checks = 0;
  int                         cycles = 0;

  cvt_regs cvt_regs_inst (
    .clock_i(clock), .rst_i(rst), .awaddr_i(awaddr), .awvalid_i(awvalid),
    .awready_o(awready), .wdata_i(wdata), .wstrb_i(4'hf), .wvalid_i(wvalid),
    .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(1'b1),
    .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready), .rdata_o(rdata),
    .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(1'b1),
    .calibration_halted_flag_i(halted), .skew_sel_i(sel), .trim_o(trim),
    .applied_skew_o(askew), .applied_skew_ok_o(askew_ok), .address_hold_o(hold),
    .vector_valid_o(vvalid)
  );

  always #10 clock = ~clock;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // Hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic axw(input logic [9:0] idx, input logic [7:0] d, output logic [1:0] r);
    bit a;
    bit w;
    a = 1'b0;
    w = 1'b0;
    awaddr  <= {idx, 2'b00};
    wdata   <= 32'(d);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    forever begin
      @(posedge clock);
      if (!a && awready) begin
        a = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid) break;
    end
    r = bresp;
  endtask : axw

  task automatic axr(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
    bit a;
    a = 1'b0;
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    forever begin
      @(posedge clock);
      if (!a && arready) begin
        a = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
  endtask : axr

  function automatic logic [7:0] fexp(int i);
    logic [63:0] f;
    f = cvt_pkg::FACTORY_TRIM;
    fexp = f[63-8*i -: 8];
    if (i == 2) fexp = fexp & cvt_pkg::REF_MASK;
  endfunction : fexp

  function automatic logic [7:0] pat(int i);
    pat = 8'(i * 7 + 1);
  endfunction : pat

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    chk("ref reserved", 64'(trim.ref_v[7:4]), 64'h0);
    for (int i = 0; i < 8; i++) begin
      axr(TIDX[i], d, r);
      chk("trim reset", 64'(d), 64'(fexp(i)));
      chk("trim out", 64'(trim[63-8*i -: 8]), 64'(fexp(i)));
    end
  endtask : t_reset

  task automatic t_trim();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 8; i++) begin
      wv[i] = 8'(8'h11 * (i + 1));
      axw(TIDX[i], wv[i], r);
      chk("write resp", 64'(r), 64'(cvt_pkg::RESP_OKAY));
    end
    for (int i = 0; i < 8; i++) begin
      axr(TIDX[i], d, r);
      chk("trim read", 64'(d), 64'(wv[i]));
    end
    chk("trim_o", trim, {wv[0], wv[1], wv[2], wv[3], wv[4], wv[5], wv[6], wv[7]});
    axw(10'h07d, 8'hff, r);
    chk("hole write resp", 64'(r), 64'(cvt_pkg::RESP_SLVERR));
    axr(10'h07d, d, r);
    chk("hole read resp", 64'(r), 64'(cvt_pkg::RESP_SLVERR));
    chk("trim_o kept", trim, {wv[0], wv[1], wv[2], wv[3], wv[4], wv[5], wv[6], wv[7]});
  endtask : t_trim

  task automatic t_skew();
    logic       ok;
    logic [7:0] e;
    for (int s = 0; s < 8; s++) begin
      sel <= cvt_pkg::cvt_skew_sel_type'(3'(s));
      repeat (2) @(posedge clock);
      ok = !s[1] && !(s[2] && s[0]);
      e  = !ok ? 8'h00 : (s[2] ? wv[6] : (s[0] ? wv[7] : wv[5]));
      chk("skew ok", 64'(askew_ok), 64'(ok));
      chk("skew value", 64'(askew), 64'(e));
    end
  endtask : t_skew

  task automatic t_hold();
    logic [31:0] d;
    logic [1:0]  r;
    axw(cvt_pkg::IDX_CFG, 8'h01, r);
    chk("address hold", 64'(hold), 64'h1);
    axr(cvt_pkg::IDX_CFG, d, r);
    chk("cfg read", 64'(d), 64'h1);
  endtask : t_hold

  task automatic t_vector();
    logic [31:0] d;
    logic [1:0]  r;
    halted <= 1'b1;
    axw(cvt_pkg::IDX_CAL_EN, 8'h01, r);
    for (int i = 0; i < cvt_pkg::VEC_LEN; i++) begin
      axw(cvt_pkg::IDX_CAL_DATA, pat(i), r);
    end
    chk("valid after load", 64'(vvalid), 64'h1);
    axr(cvt_pkg::IDX_STAT, d, r);
    chk("stat after load", 64'({d[25:16], d[1:0]}), 64'({10'h000, 2'b11}));
    // Partial transfer while the vector is valid, then cut it short
    for (int i = 0; i < 5; i++) begin
      axr(cvt_pkg::IDX_CAL_DATA, d, r);
      chk("partial read", 64'(d), 64'(pat(i)));
    end
    axr(cvt_pkg::IDX_STAT, d, r);
    chk("stat partial", 64'({d[25:16], d[1:0]}), 64'({10'h005, 2'b11}));
    axw(cvt_pkg::IDX_CAL_EN, 8'h00, r);
    chk("valid aborted", 64'(vvalid), 64'h0);
    axw(cvt_pkg::IDX_CAL_EN, 8'h01, r);
    for (int i = 0; i < cvt_pkg::VEC_LEN; i++) begin
      axr(cvt_pkg::IDX_CAL_DATA, d, r);
      chk("vector read", 64'(d), 64'(pat(i)));
    end
    chk("valid after read", 64'(vvalid), 64'h1);
    halted <= 1'b0;
    axr(cvt_pkg::IDX_CAL_DATA, d, r);
    chk("valid unhalted", 64'(vvalid), 64'h0);
    halted <= 1'b1;
    axw(cvt_pkg::IDX_CAL_EN, 8'h00, r);
    axr(cvt_pkg::IDX_CAL_DATA, d, r);
    chk("port disabled", 64'({d, r}), 64'({32'h0000_0000, cvt_pkg::RESP_OKAY}));
  endtask : t_vector

  initial begin
    rst     = 1'b1;
    awaddr  = 12'h000;
    awvalid = 1'b0;
    wdata   = 32'h0000_0000;
    wvalid  = 1'b0;
    araddr  = 12'h000;
    arvalid = 1'b0;
    halted  = 1'b0;
    sel     = cvt_pkg::cvt_skew_sel_type'(3'h0);
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    t_reset();
    t_trim();
    t_skew();
    t_hold();
    t_vector();
    give_verdict();
  end
endmodule : test_calibration_vector_and_trim_regs
